// >>> rtl/two_wire_unit.v
// byte-oriented two-wire bus unit: master and slave, register port
// assumes open-drain lines resolved outside; scl/sda are asynchronous
`timescale 1ns/1ps
`include "two_wire_consts.vh"
module two_wire_unit (
  input wire i_clk_sys, // system clock, 40 MHz
  input wire i_nrst, // synchronous reset, active low
  input wire [2:0] i_addr, // register index
  input wire [7:0] i_wdata, // write data
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  output reg [7:0] o_rdata, // read data, cycle after i_rd
  input wire i_scl, // clock line level
  output reg o_scl_out, // clock line drive level, always low
  output reg o_scl_oe, // pull clock line low
  input wire i_sda, // data line level
  output reg o_sda_out, // data line drive level, always low
  output reg o_sda_oe, // pull data line low
  output reg o_done // transfer-done flag
);
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_START = 6'b000010;
  localparam [5:0] S_BIT = 6'b000100;
  localparam [5:0] S_STOP = 6'b001000;
  localparam [5:0] S_HOLD = 6'b010000;
  localparam [5:0] S_SLV = 6'b100000;

  reg [5:0] state;
  reg [1:0] phase;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] data_reg;
  reg [7:0] code;
  reg [1:0] presc;
  reg [7:0] bitrate;
  reg [6:0] own_addr;
  reg ack_en, sta, sto, wcol, en;
  reg master, slave, tx, rd_dir, addr_phase, restart, busy;
  reg [1:0] mode;
  reg scl_d, sda_d;
  wire scl_s, sda_s, tick;

  // open-drain drive; the enable is the inverse of the wanted line level
  function drive_low;
    input t;
    input [3:0] n;
    input bit_val;
    input ack_val;
    begin
      if (t)
        drive_low = (n < 4'h8) & ~bit_val;
      else
        drive_low = (n == 4'h8) & ack_val;
    end
  endfunction

  function [7:0] step_code;
    input slv;
    input rd;
    input adr;
    input ack;
    begin
      if (!slv) begin
        if (adr)
          step_code = rd ? (ack ? `ST_MR_ADDR_ACK : `ST_MR_ADDR_NACK)
                         : (ack ? `ST_MT_ADDR_ACK : `ST_MT_ADDR_NACK);
        else
          step_code = rd ? (ack ? `ST_MR_DATA_ACK : `ST_MR_DATA_NACK)
                         : (ack ? `ST_DATA_SENT_ACKED_CODE : `ST_MT_DATA_NACK);
      end else begin
        if (adr)
          step_code = rd ? `ST_ST_ADDR_ACK : `ST_SR_ADDR_ACK;
        else
          step_code = rd ? (ack ? `ST_ST_DATA_ACK : `ST_ST_DATA_NACK)
                         : (ack ? `ST_SR_DATA_ACK : `ST_SR_DATA_NACK);
      end
    end
  endfunction

  two_wire_sync u_scl_sync (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_async(i_scl),
    .o_sync(scl_s)
  );

  two_wire_sync u_sda_sync (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_async(i_sda),
    .o_sync(sda_s)
  );

  wire [13:0] tick_limit = {6'h00, bitrate} << {presc, 1'b0};

  two_wire_tick u_tick (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_run(en),
    .i_limit(tick_limit),
    .o_tick(tick)
  );

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = ~sda_s & sda_d & scl_s & scl_d;
  wire bus_stop = sda_s & ~sda_d & scl_s & scl_d;
  wire addr_match = (shreg[7:1] == own_addr);
  wire ack_drive = ack_en & (~slave | ~addr_phase | addr_match);
  wire wr_ctrl = i_wr & (i_addr == `REG_CTRL);
  wire wr_data = i_wr & (i_addr == `REG_DATA);
  wire next_sda_oe = drive_low(tx, bitcnt, shreg[7], ack_drive);

  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state <= S_IDLE;
      phase <= 2'h0;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      data_reg <= 8'hff;
      code <= `STATUS_RESET;
      presc <= 2'h0;
      bitrate <= `BITRATE_RESET;
      own_addr <= `OWN_ADDR_RESET;
      o_done <= 1'b0;
      ack_en <= 1'b0;
      sta <= 1'b0;
      sto <= 1'b0;
      wcol <= 1'b0;
      en <= 1'b0;
      master <= 1'b0;
      slave <= 1'b0;
      tx <= 1'b0;
      rd_dir <= 1'b0;
      addr_phase <= 1'b0;
      restart <= 1'b0;
      busy <= 1'b0;
      mode <= `MODE_MT;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      // register reads, data valid only in the following cycle
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `REG_CTRL: o_rdata <= {o_done, ack_en, sta, sto, wcol, en, 2'h0};
          `REG_STATUS: o_rdata <= {code[7:3], 1'b0, presc};
          `REG_DATA: o_rdata <= data_reg;
          `REG_OWN_ADDR: o_rdata <= {own_addr, 1'b0};
          `REG_BITRATE: o_rdata <= bitrate;
          `REG_MODE: o_rdata <= {5'h00, master | slave, mode};
          default: o_rdata <= 8'h00;
        endcase
      end
      if (wr_ctrl) begin
        if (i_wdata[`CTRL_DONE])
          o_done <= 1'b0;
        ack_en <= i_wdata[`CTRL_ACK_EN];
        sta <= i_wdata[`CTRL_START];
        sto <= i_wdata[`CTRL_STOP];
        en <= i_wdata[`CTRL_ENABLE];
      end
      if (i_wr & (i_addr == `REG_STATUS))
        presc <= i_wdata[1:0];
      if (i_wr & (i_addr == `REG_OWN_ADDR))
        own_addr <= i_wdata[7:1];
      if (i_wr & (i_addr == `REG_BITRATE))
        bitrate <= i_wdata;
      if (wr_data) begin
        if (o_done) begin
          data_reg <= i_wdata;
          wcol <= 1'b0;
        end else begin
          wcol <= 1'b1;
        end
      end
      if (bus_start)
        busy <= 1'b1;
      if (bus_stop)
        busy <= 1'b0;
      // hardware sets below come last so a set beats a clear
      if (!en) begin
        state <= S_IDLE;
        o_scl_oe <= 1'b0;
        o_sda_oe <= 1'b0;
        master <= 1'b0;
        slave <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            o_scl_oe <= 1'b0;
            o_sda_oe <= 1'b0;
            if (sta & ~busy) begin
              state <= S_START;
              phase <= 2'h0;
              restart <= 1'b0;
            end else if (bus_start & ack_en) begin
              state <= S_SLV;
              slave <= 1'b1;
              addr_phase <= 1'b1;
              bitcnt <= 4'h0;
              tx <= 1'b0;
            end
          end
          S_START: if (tick) begin
            case (phase)
              2'h0: o_sda_oe <= 1'b0;
              2'h1: o_scl_oe <= 1'b0;
              2'h2: o_sda_oe <= 1'b1;
              default: begin
                o_scl_oe <= 1'b1;
                o_done <= 1'b1;
                code <= restart ? `ST_RESTART : `ST_START;
                master <= 1'b1;
                slave <= 1'b0;
                addr_phase <= 1'b1;
                state <= S_HOLD;
              end
            endcase
            if (phase != 2'h1 | scl_s)
              phase <= phase + 2'h1;
          end
          S_HOLD: begin
            if (slave & scl_fall) begin
              o_scl_oe <= 1'b1;
              o_sda_oe <= 1'b0;
            end
            if (!o_done) begin
              bitcnt <= 4'h0;
              phase <= 2'h0;
              if (master) begin
                if (sto) begin
                  state <= S_STOP;
                end else if (sta) begin
                  state <= S_START;
                  restart <= 1'b1;
                end else begin
                  state <= S_BIT;
                  shreg <= data_reg;
                  tx <= addr_phase | ~rd_dir;
                  if (addr_phase)
                    rd_dir <= data_reg[0];
                end
              end else if (slave) begin
                state <= S_SLV;
                shreg <= data_reg;
                o_scl_oe <= 1'b0;
                if (!scl_s)
                  o_sda_oe <= tx & ~data_reg[7];
              end else begin
                state <= sta ? S_START : S_IDLE;
                restart <= 1'b0;
              end
            end
          end
          S_BIT: if (tick) begin
            case (phase)
              2'h0: o_sda_oe <= next_sda_oe;
              2'h1: o_scl_oe <= 1'b0;
              2'h2: begin
                if (bitcnt < 4'h8)
                  shreg <= {shreg[6:0], sda_s};
                if (tx & (bitcnt < 4'h8) & ~o_sda_oe & ~sda_s) begin
                  o_sda_oe <= 1'b0;
                  o_scl_oe <= 1'b0;
                  master <= 1'b0;
                  o_done <= 1'b1;
                  code <= `ST_ARB_LOST;
                  state <= S_HOLD;
                end else if (bitcnt == 4'h8) begin
                  code <= step_code(1'b0, rd_dir, addr_phase, ~sda_s);
                end
              end
              default: begin
                o_scl_oe <= 1'b1;
                if (bitcnt == 4'h8) begin
                  o_sda_oe <= 1'b0;
                  o_done <= 1'b1;
                  if (addr_phase)
                    mode <= rd_dir ? `MODE_MR : `MODE_MT;
                  else if (!tx)
                    data_reg <= shreg;
                  addr_phase <= 1'b0;
                  state <= S_HOLD;
                end else begin
                  bitcnt <= bitcnt + 4'h1;
                end
              end
            endcase
            if ((phase != 2'h1 | scl_s) & state == S_BIT)
              phase <= phase + 2'h1;
          end
          S_SLV: begin
            if (bus_stop) begin
              o_sda_oe <= 1'b0;
              slave <= 1'b0;
              state <= S_IDLE;
              if (!addr_phase) begin
                o_done <= 1'b1;
                code <= `ST_SR_STOP;
              end
            end else if (bus_start) begin
              o_sda_oe <= 1'b0;
              addr_phase <= 1'b1;
              bitcnt <= 4'h0;
              tx <= 1'b0;
            end else if (scl_fall) begin
              o_sda_oe <= next_sda_oe;
            end else if (scl_rise) begin
              if (bitcnt < 4'h8) begin
                shreg <= {shreg[6:0], sda_s};
                bitcnt <= bitcnt + 4'h1;
              end else if (addr_phase & ~(addr_match & ack_en)) begin
                slave <= 1'b0;
                state <= S_IDLE;
              end else begin
                o_done <= 1'b1;
                state <= S_HOLD;
                addr_phase <= 1'b0;
                if (addr_phase) begin
                  tx <= shreg[0];
                  mode <= shreg[0] ? `MODE_ST : `MODE_SR;
                  code <= step_code(1'b1, shreg[0], 1'b1, 1'b1);
                end else begin
                  code <= step_code(1'b1, tx, 1'b0, ~sda_s);
                  if (!tx)
                    data_reg <= shreg;
                  if (tx & sda_s)
                    slave <= 1'b0;
                end
              end
            end
          end
          S_STOP: if (tick) begin
            case (phase)
              2'h0: o_sda_oe <= 1'b1;
              2'h1: o_scl_oe <= 1'b0;
              2'h2: o_sda_oe <= 1'b0;
              default: begin
                sto <= 1'b0;
                master <= 1'b0;
                restart <= 1'b0;
                state <= sta ? S_START : S_IDLE;
              end
            endcase
            if (phase != 2'h1 | scl_s)
              phase <= phase + 2'h1;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule // two_wire_unit

// >>> rtl/two_wire_consts.vh
// register offsets, field positions, reset values and status codes
// for the two-wire unit; included by every design file that needs them
`ifndef TWO_WIRE_CONSTS_VH
`define TWO_WIRE_CONSTS_VH

// register indices on the 3-bit register port
`define REG_CTRL 3'h0
`define REG_STATUS 3'h1
`define REG_DATA 3'h2
`define REG_OWN_ADDR 3'h3
`define REG_BITRATE 3'h4
`define REG_MODE 3'h5

// control register fields
`define CTRL_DONE 7
`define CTRL_ACK_EN 6
`define CTRL_START 5
`define CTRL_STOP 4
`define CTRL_WCOL 3
`define CTRL_ENABLE 2

// reset values and status read mask
`define STATUS_RESET 8'hf8
`define BITRATE_RESET 8'h20
`define OWN_ADDR_RESET 7'h00
`define STATUS_MASK 8'hf8

// operating modes
`define MODE_MT 2'h0
`define MODE_MR 2'h1
`define MODE_ST 2'h2
`define MODE_SR 2'h3

// status codes
`define ST_START 8'h08
`define ST_RESTART 8'h10
`define ST_MT_ADDR_ACK 8'h18
`define ST_MT_ADDR_NACK 8'h20
`define ST_DATA_SENT_ACKED_CODE 8'h28
`define ST_MT_DATA_NACK 8'h30
`define ST_ARB_LOST 8'h38
`define ST_MR_ADDR_ACK 8'h40
`define ST_MR_ADDR_NACK 8'h48
`define ST_MR_DATA_ACK 8'h50
`define ST_MR_DATA_NACK 8'h58
`define ST_SR_ADDR_ACK 8'h60
`define ST_SR_DATA_ACK 8'h80
`define ST_SR_DATA_NACK 8'h88
`define ST_SR_STOP 8'ha0
`define ST_ST_ADDR_ACK 8'ha8
`define ST_ST_DATA_ACK 8'hb8
`define ST_ST_DATA_NACK 8'hc0

`endif

// >>> rtl/two_wire_sync.v
// two-flip-flop synchroniser for one bus line
// assumes the input is asynchronous to i_clk_sys
`timescale 1ns/1ps
module two_wire_sync (
  input wire i_clk_sys, // system clock
  input wire i_nrst, // synchronous reset, active low
  input wire i_async, // raw line level
  output reg o_sync // synchronised level
);
  reg meta;

  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      meta <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // two_wire_sync

// >>> rtl/two_wire_tick.v
// quarter-bit tick generator for the master bit engine
// assumes i_limit is steady while a transfer runs
`timescale 1ns/1ps
module two_wire_tick (
  input wire i_clk_sys, // system clock
  input wire i_nrst, // synchronous reset, active low
  input wire i_run, // count while high
  input wire [13:0] i_limit, // cycles between ticks minus one
  output reg o_tick // one-cycle pulse
);
  reg [13:0] count;

  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      count <= 14'h0000;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      count <= 14'h0000;
      o_tick <= 1'b0;
    end else if (count >= i_limit) begin
      count <= 14'h0000;
      o_tick <= 1'b1;
    end else begin
      count <= count + 14'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule // two_wire_tick

// >>> testbench/two_wire_unit_props.sv
// checker for the two-wire unit: sees only the unit's ports
// assumes one clock domain and the bench's bus master behaviour
`timescale 1ns/1ps
`include "two_wire_consts.vh"
module two_wire_unit_checker (
  input wire i_clk_sys, // system clock
  input wire i_nrst, // reset, active low
  input wire [2:0] i_addr, // register index
  input wire [7:0] i_wdata, // write data
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  input wire [7:0] o_rdata, // read data
  input wire i_scl, // clock line
  input wire o_scl_out, // clock drive level
  input wire o_scl_oe, // clock pull enable
  input wire i_sda, // data line
  input wire o_sda_out, // data drive level
  input wire o_sda_oe, // data pull enable
  input wire o_done // done flag
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  wire clr_w = i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_DONE];
  property p_done_hold;
    o_done && !clr_w |=> o_done;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done flag fell without a clear");
  property p_done_clear;
    o_done && clr_w |=> !o_done;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done flag not cleared by a one");
  property p_hold_lines;
    o_done && o_scl_oe && $past(o_done && o_scl_oe) |-> $stable(o_sda_oe);
  endproperty
  a_hold_lines: assert property (p_hold_lines)
    else $error("data line moved while suspended");
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read");
  property p_status_bit2;
    $past(i_rd) && $past(i_addr) == `REG_STATUS |-> o_rdata[2] == 1'b0;
  endproperty
  a_status_bit2: assert property (p_status_bit2)
    else $error("status bit 2 not zero");
  property p_ctrl_done;
    $past(i_rd) && $past(i_addr) == `REG_CTRL
      |-> o_rdata[7] == $past(o_done) && o_rdata[1:0] == 2'b00;
  endproperty
  a_ctrl_done: assert property (p_ctrl_done)
    else $error("control read disagrees with done");
  property p_unmapped;
    $past(i_rd) && $past(i_addr) > 3'h5 |-> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_open_drain;
    o_sda_out == 1'b0 && o_scl_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line drive level not low");
  property p_wcol;
    i_wr && i_addr == `REG_DATA && !o_done ##1 !i_wr
      ##1 i_rd && i_addr == `REG_CTRL |=> o_rdata[`CTRL_WCOL];
  endproperty
  a_wcol: assert property (p_wcol)
    else $error("write collision not flagged");
  c_done: cover property ($rose(o_done));
  c_clear: cover property (o_done && clr_w);
  c_start: cover property ($rose(o_sda_oe) && !o_scl_oe);
endmodule // two_wire_unit_checker
bind two_wire_unit two_wire_unit_checker i_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_scl(i_scl), .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe),
  .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_done(o_done)
);

// >>> testbench/bus_receiver_model.sv
// behavioural slave receiver on the two-wire bus
// assumes resolved, pulled-up lines; acks every byte unless told not to
`timescale 1ns/1ps
module bus_receiver_model (
  input wire i_scl, // resolved clock line
  input wire i_sda, // resolved data line
  input wire i_nack, // answer not-ack when high
  output reg o_sda_oe, // pull data line low
  output reg [7:0] o_last, // last byte seen
  output integer o_bytes, // bytes seen
  output integer o_starts, // starts seen
  output integer o_stops // stops seen
);
  integer cnt;
  reg [7:0] shift;
  initial begin
    o_sda_oe = 1'b0;
    o_last = 8'h00;
    o_bytes = 0;
    o_starts = 0;
    o_stops = 0;
    cnt = 0;
    shift = 8'h00;
  end
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    o_starts = o_starts + 1;
    cnt = 0;
  end
  always @(posedge i_sda) if (i_scl === 1'b1) begin
    o_stops = o_stops + 1;
    cnt = 0;
  end
  // msb first, eight bits then the ack bit
  always @(posedge i_scl) begin
    if (cnt < 8) shift = {shift[6:0], i_sda};
    cnt = (cnt == 8) ? 0 : cnt + 1;
  end
  // low at the ack bit is ack, released is not-ack
  always @(negedge i_scl) begin
    o_sda_oe = (cnt == 8) && !i_nack;
    if (cnt == 8) begin
      o_last = shift;
      o_bytes = o_bytes + 1;
    end
  end
endmodule // bus_receiver_model

// >>> testbench/two_wire_unit_tb_top.sv
// self-checking bench: unit as master towards a slave receiver model,
// then as slave receiver behind a master driven by the bench
// assumes open-drain lines with pull-ups, resolved here
`timescale 1ns/1ps
`include "two_wire_consts.vh"
module two_wire_unit_tb_top;
  reg i_clk_sys = 1'b0;
  reg i_nrst = 1'b0;
  reg [2:0] i_addr = 3'h0;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg nack = 1'b0;
  reg m_scl = 1'b0;
  reg m_sda = 1'b0;
  wire [7:0] o_rdata;
  wire scl_oe, sda_oe, slv_oe, o_done;
  wire [7:0] last;
  integer bytes, starts, stops;
  integer errors = 0;
  integer check_count = 0;
  wire scl = !(scl_oe || m_scl);
  wire sda = !(sda_oe || slv_oe || m_sda);
  two_wire_unit i_two_wire_unit (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_scl(scl), .o_scl_out(), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe), .o_done(o_done));
  bus_receiver_model i_bus_receiver_model (.i_scl(scl), .i_sda(sda),
    .i_nack(nack), .o_sda_oe(slv_oe), .o_last(last), .o_bytes(bytes),
    .o_starts(starts), .o_stops(stops));
  initial forever #12.5 i_clk_sys = !i_clk_sys;
  task automatic check(input [7:0] got, input [7:0] exp, input [63:0] s);
    check_count = check_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %0t %0s got %h want %h", $time, s, got, exp);
    end
  endtask
  task automatic wr(input [2:0] a, input [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic chk_reg(input [2:0] a, input [7:0] m, input [7:0] e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    check(o_rdata & m, e, "register");
  endtask
  task automatic wait_done;
    integer n;
    n = 0;
    @(negedge i_clk_sys);
    while (o_done !== 1'b1 && n < 2000) begin
      @(negedge i_clk_sys);
      n = n + 1;
    end
    check({7'h00, o_done}, 8'h01, "done");
  endtask
  task automatic xfer(input [7:0] d, input [7:0] code);
    wr(`REG_DATA, d);
    wr(`REG_CTRL, 8'h84);
    wait_done;
    chk_reg(`REG_STATUS, `STATUS_MASK, code);
  endtask
  task automatic start;
    wr(`REG_CTRL, 8'ha4);
    wait_done;
    chk_reg(`REG_STATUS, `STATUS_MASK, `ST_START);
  endtask
  task automatic stop;
    integer n, s0;
    s0 = stops;
    n = 0;
    wr(`REG_CTRL, 8'h94);
    while (stops == s0 && n < 500) begin
      @(posedge i_clk_sys);
      n = n + 1;
    end
    check(stops - s0, 8'h01, "stop");
    chk_reg(`REG_CTRL, 8'h10, 8'h00);
  endtask
  // bench as second master: 200 ns per bit, waits out clock stretching
  task automatic bb_bit(input b, output r);
    @(posedge i_clk_sys);
    m_sda <= !b;
    repeat (3) @(posedge i_clk_sys);
    m_scl <= 1'b0;
    @(posedge i_clk_sys);
    while (scl !== 1'b1) @(posedge i_clk_sys);
    repeat (3) @(posedge i_clk_sys);
    r = sda;
    m_scl <= 1'b1;
  endtask
  task automatic bb_byte(input [7:0] d, output r);
    integer i;
    reg x;
    for (i = 7; i >= 0; i = i - 1)
      bb_bit(d[i], x);
    bb_bit(1'b1, r);
  endtask
  task automatic bb_start;
    @(posedge i_clk_sys);
    m_sda <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    m_scl <= 1'b1;
  endtask
  task automatic bb_stop;
    @(posedge i_clk_sys);
    m_sda <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    m_scl <= 1'b0;
    @(posedge i_clk_sys);
    while (scl !== 1'b1) @(posedge i_clk_sys);
    repeat (3) @(posedge i_clk_sys);
    m_sda <= 1'b0;
  endtask
  task automatic t_reset_regs;
    chk_reg(`REG_STATUS, 8'hff, `STATUS_RESET);
    chk_reg(`REG_BITRATE, 8'hff, `BITRATE_RESET);
    chk_reg(3'h6, 8'hff, 8'h00);
    wr(`REG_BITRATE, 8'h01);
    wr(`REG_DATA, 8'h5a);
    chk_reg(`REG_CTRL, 8'h08, 8'h08);
    $display("test reset_regs done");
  endtask
  task automatic t_master_write;
    integer b0, n;
    reg bad;
    b0 = bytes;
    start;
    check(starts, 8'h01, "starts");
    wr(`REG_CTRL, 8'h04);
    bad = 1'b0;
    for (n = 0; n < 40; n = n + 1) begin
      @(negedge i_clk_sys);
      if (scl !== 1'b0 || o_done !== 1'b1) bad = 1'b1;
    end
    check({7'h00, bad}, 8'h00, "stall");
    check(bytes - b0, 8'h00, "stall");
    wr(`REG_DATA, 8'ha0);
    chk_reg(`REG_CTRL, 8'h08, 8'h00);
    wr(`REG_CTRL, 8'h84);
    wait_done;
    chk_reg(`REG_STATUS, `STATUS_MASK, `ST_MT_ADDR_ACK);
    check(last, 8'ha0, "address");
    chk_reg(`REG_MODE, 8'h03, {6'h00, `MODE_MT});
    xfer(8'h3c, `ST_DATA_SENT_ACKED_CODE);
    check(last, 8'h3c, "data");
    check(bytes - b0, 8'h02, "bytes");
    stop;
    $display("test master_write done");
  endtask
  task automatic t_nack_read;
    nack <= 1'b1;
    start;
    xfer(8'ha0, `ST_MT_ADDR_NACK);
    xfer(8'h55, `ST_MT_DATA_NACK);
    stop;
    nack <= 1'b0;
    start;
    xfer(8'ha1, `ST_MR_ADDR_ACK);
    check(last, 8'ha1, "address");
    chk_reg(`REG_MODE, 8'h03, {6'h00, `MODE_MR});
    nack <= 1'b1;
    wr(`REG_CTRL, 8'h84);
    wait_done;
    chk_reg(`REG_STATUS, `STATUS_MASK, `ST_MR_DATA_NACK);
    chk_reg(`REG_DATA, 8'hff, 8'hff);
    stop;
    nack <= 1'b0;
    $display("test nack_read done");
  endtask
  task automatic t_slave_receive;
    reg ack;
    nack <= 1'b1;
    wr(`REG_OWN_ADDR, 8'h52);
    wr(`REG_CTRL, 8'h44);
    bb_start;
    bb_byte(8'h52, ack);
    check({7'h00, ack}, 8'h00, "addr ack");
    wait_done;
    chk_reg(`REG_STATUS, `STATUS_MASK, `ST_SR_ADDR_ACK);
    chk_reg(`REG_MODE, 8'h03, {6'h00, `MODE_SR});
    check({7'h00, scl_oe}, 8'h01, "stretch");
    wr(`REG_CTRL, 8'hc4);
    bb_byte(8'h96, ack);
    check({7'h00, ack}, 8'h00, "data ack");
    wait_done;
    chk_reg(`REG_STATUS, `STATUS_MASK, `ST_SR_DATA_ACK);
    chk_reg(`REG_DATA, 8'hff, 8'h96);
    wr(`REG_CTRL, 8'hc4);
    bb_stop;
    wait_done;
    chk_reg(`REG_STATUS, `STATUS_MASK, `ST_SR_STOP);
    nack <= 1'b0;
    $display("test slave_receive done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    errors = errors + 1;
    $display("MISMATCH %0t watchdog expired", $time);
    conclude;
  end
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    t_reset_regs;
    t_master_write;
    t_nack_read;
    t_slave_receive;
    conclude;
  end
endmodule // two_wire_unit_tb_top
